// [rtl/dual_clock_fifo_flag_modes.sv]
// What this block does
// - mode pin at master reset: low gives standard, high gives fall-through.
// - fall-through: first word reaches output after three read clock edges unrequested.
// - producer holds write enable low; data captured on write clock rising edges.
// - standard: empty flag rises after first word is written.
// - standard: almost-empty high above n words, low again at n.
// - standard: half-full low from half depth plus one words.
// - standard: almost-full low from depth minus m words.
// - standard: full flag low at depth, blocks writes; first read releases it.
// - almost-full and half-full release at the same thresholds while draining.
// - standard: empty flag low after last read; read enable ignored while empty.
// - standard: empty and full flags pass two stages in their own clock.
// - fall-through: output ready low once first word sits on the output.
// - fall-through: almost-empty high above n plus one, low at n plus one.
// - fall-through: half-full low from half depth plus two words.
// - fall-through: almost-full low from depth plus one minus m words.
// - fall-through: input ready high at depth plus one words, blocking writes.
// - fall-through: first read from full drives input ready low again.
// - fall-through: output ready high after last read; read enable ignored.
// - fall-through: output ready three stages, input ready two stages.
// - load pin high at reset: serial loading, empty offset preset 3FF.
// - load pin low at reset: parallel loading, both offsets preset 07F.
// - offsets read back only over the parallel register port.
// - offsets may be rewritten any time after master reset.
// - serial loading presets the full offset to 3FF as well.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
module dual_clock_fifo_flag_modes #(
    parameter int unsigned DEPTH = fifo_flag_pkg::DEPTH_SMALL,
    parameter int unsigned DATA_W = fifo_flag_pkg::DATA_W,
    parameter int unsigned OFS_W = fifo_flag_pkg::OFS_W
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic write_clock_in,
    input wire logic read_clock_in,
    input wire logic write_enable_n_in,
    input wire logic read_enable_n_in,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic mode_select_serial_in,
    input wire logic load_n_in,
    input wire logic [1:0] reg_addr_in,
    input wire logic [fifo_flag_pkg::REG_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [fifo_flag_pkg::REG_W-1:0] reg_rdata_out,
    output logic [DATA_W-1:0] data_out,
    output logic empty_flag_n_out,
    output logic full_flag_n_out,
    output logic output_ready_n_out,
    output logic input_ready_n_out,
    output logic almost_empty_flag_n_out,
    output logic almost_full_flag_n_out,
    output logic half_full_flag_n_out,
    output logic fall_through_mode_out
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = AW + 2;
    localparam int unsigned PW = fifo_flag_pkg::PINS_W;
    localparam logic [CW-1:0] CAP_STD = CW'(DEPTH);
    localparam logic [CW-1:0] CAP_FALL = CW'(DEPTH + 1);
    localparam logic [CW-1:0] HALF_STD = CW'(DEPTH / 2 + 1);
    localparam logic [CW-1:0] HALF_FALL = CW'(DEPTH / 2 + 2);

    typedef struct packed {
        logic [1:0] init_cnt;
        logic ready;
        logic fall_through;
        logic serial;
        logic [OFS_W-1:0] empty_ofs;
        logic [OFS_W-1:0] full_ofs;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [CW-1:0] held;
        fifo_flag_pkg::out_state_t out_st;
        logic [1:0] fall_cnt;
        logic [DATA_W-1:0] dout;
        logic ef1;
        logic ef2;
        logic ff1;
        logic ff2;
        logic ir1;
        logic ir2;
        logic almost_empty_flag_n;
        logic almost_full_flag_n;
        logic hf;
        logic [fifo_flag_pkg::REG_W-1:0] rdata;
    } fifo_state_t;

    fifo_state_t s_ff;
    fifo_state_t nxt_s;
    logic [DATA_W-1:0] mem [DEPTH];

    pin_sample_if #(.W(PW)) pins_if ();

    assign pins_if.pins = {data_in, load_n_in, mode_select_serial_in, read_enable_n_in,
                           write_enable_n_in, read_clock_in, write_clock_in};

    pin_sampler #(.W(PW)) u_pins (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .smp(pins_if.sampler)
    );

    function automatic logic [CW-1:0] widen(input logic [OFS_W-1:0] v);
        widen = CW'(v);
    endfunction

    logic wr_edge;
    logic rd_edge;
    logic wen_low;
    logic ren_low;
    logic [DATA_W-1:0] din;
    logic [CW-1:0] mem_cnt;
    logic wr_ok;
    logic pop;
    logic [CW-1:0] held_nxt;
    logic [fifo_flag_pkg::REG_W-1:0] status;

    assign wr_edge = pins_if.rise[fifo_flag_pkg::PIN_WCLK] & s_ff.ready;
    assign rd_edge = pins_if.rise[fifo_flag_pkg::PIN_RCLK] & s_ff.ready;
    assign wen_low = ~pins_if.level[fifo_flag_pkg::PIN_WEN];
    assign ren_low = ~pins_if.level[fifo_flag_pkg::PIN_REN];
    // data travels the same two stages as the clock, so it lines up with the edge
    assign din = pins_if.level[fifo_flag_pkg::PIN_DATA +: DATA_W];

    // words in the array; the output register in fall-through is outside it
    assign mem_cnt = s_ff.held - CW'(s_ff.out_st == fifo_flag_pkg::OUT_VALID);

    // the array is the only limit, so writes stop exactly at the documented capacity
    assign wr_ok = wr_edge & wen_low & (mem_cnt < CAP_STD);

    always_comb begin
        pop = 1'b0;
        if (rd_edge & ren_low) begin
            if (!s_ff.fall_through) begin
                pop = (s_ff.held != '0);
            end else begin
                pop = (s_ff.out_st == fifo_flag_pkg::OUT_VALID);
            end
        end
    end

    // one counter sees both events, so a write and a read together cancel out
    assign held_nxt = s_ff.held + CW'(wr_ok) - CW'(pop);

    always_comb begin
        status = '0;
        status[fifo_flag_pkg::ST_FALL_THROUGH] = s_ff.fall_through;
        status[fifo_flag_pkg::ST_SERIAL] = s_ff.serial;
        status[fifo_flag_pkg::ST_EMPTY_N] = empty_flag_n_out;
        status[fifo_flag_pkg::ST_FULL_N] = full_flag_n_out;
        status[fifo_flag_pkg::ST_OUT_READY_N] = output_ready_n_out;
        status[fifo_flag_pkg::ST_IN_READY_N] = input_ready_n_out;
        status[fifo_flag_pkg::ST_ALMOST_EMPTY_N] = s_ff.almost_empty_flag_n;
        status[fifo_flag_pkg::ST_ALMOST_FULL_N] = s_ff.almost_full_flag_n;
        status[fifo_flag_pkg::ST_HALF_FULL_N] = s_ff.hf;
        status[fifo_flag_pkg::ST_COUNT_LSB +: CW] = s_ff.held;
    end

    always_comb begin
        nxt_s = s_ff;

        // straps are taken once the sampled pins have settled after release
        if (!s_ff.ready) begin
            nxt_s.init_cnt = s_ff.init_cnt + 2'h1;
            if (s_ff.init_cnt == fifo_flag_pkg::INIT_WAIT) begin
                nxt_s.ready = 1'b1;
                nxt_s.fall_through = pins_if.level[fifo_flag_pkg::PIN_MODE];
                nxt_s.serial = pins_if.level[fifo_flag_pkg::PIN_LOAD];
                if (pins_if.level[fifo_flag_pkg::PIN_LOAD]) begin
                    nxt_s.empty_ofs = OFS_W'(fifo_flag_pkg::OFS_SERIAL_PRESET);
                    nxt_s.full_ofs = OFS_W'(fifo_flag_pkg::OFS_SERIAL_PRESET);
                end else begin
                    nxt_s.empty_ofs = OFS_W'(fifo_flag_pkg::OFS_PARALLEL_PRESET);
                    nxt_s.full_ofs = OFS_W'(fifo_flag_pkg::OFS_PARALLEL_PRESET);
                end
            end
        end

        if (wr_ok) begin
            nxt_s.wptr = s_ff.wptr + AW'(1);
        end
        nxt_s.held = held_nxt;

        if (!s_ff.fall_through) begin
            if (pop) begin
                nxt_s.dout = mem[s_ff.rptr];
                nxt_s.rptr = s_ff.rptr + AW'(1);
            end
        end else if (rd_edge) begin
            unique case (s_ff.out_st)
                fifo_flag_pkg::OUT_EMPTY: begin
                    if (mem_cnt != '0) begin
                        nxt_s.out_st = fifo_flag_pkg::OUT_FALLING;
                        nxt_s.fall_cnt = 2'h0;
                    end
                end
                fifo_flag_pkg::OUT_FALLING: begin
                    // third read clock edge since the word arrived puts it on the output
                    if (s_ff.fall_cnt == fifo_flag_pkg::FALL_LOAD_AT) begin
                        nxt_s.out_st = fifo_flag_pkg::OUT_VALID;
                        nxt_s.dout = mem[s_ff.rptr];
                        nxt_s.rptr = s_ff.rptr + AW'(1);
                    end else begin
                        nxt_s.fall_cnt = s_ff.fall_cnt + 2'h1;
                    end
                end
                fifo_flag_pkg::OUT_VALID: begin
                    if (pop) begin
                        if (mem_cnt != '0) begin
                            nxt_s.dout = mem[s_ff.rptr];
                            nxt_s.rptr = s_ff.rptr + AW'(1);
                        end else begin
                            nxt_s.out_st = fifo_flag_pkg::OUT_EMPTY;
                        end
                    end
                end
                default: begin
                    nxt_s.out_st = fifo_flag_pkg::OUT_EMPTY;
                end
            endcase
        end

        // read-side flags advance on read clock edges only
        if (rd_edge) begin
            nxt_s.ef1 = (held_nxt != '0);
            nxt_s.ef2 = s_ff.ef1;
            if (s_ff.fall_through) begin
                nxt_s.almost_empty_flag_n = (held_nxt > widen(s_ff.empty_ofs) + CW'(1));
            end else begin
                nxt_s.almost_empty_flag_n = (held_nxt > widen(s_ff.empty_ofs));
            end
        end

        // write-side flags advance on write clock edges only
        if (wr_edge) begin
            nxt_s.ff1 = (held_nxt != CAP_STD);
            nxt_s.ff2 = s_ff.ff1;
            nxt_s.ir1 = (held_nxt == CAP_FALL);
            nxt_s.ir2 = s_ff.ir1;
            if (s_ff.fall_through) begin
                nxt_s.almost_full_flag_n = (held_nxt < CAP_FALL - widen(s_ff.full_ofs));
            end else begin
                nxt_s.almost_full_flag_n = (held_nxt < CAP_STD - widen(s_ff.full_ofs));
            end
        end

        // half-full follows either clock so it tracks both fill and drain
        if (wr_edge | rd_edge) begin
            if (s_ff.fall_through) begin
                nxt_s.hf = (held_nxt < HALF_FALL);
            end else begin
                nxt_s.hf = (held_nxt < HALF_STD);
            end
        end

        // offsets: writable any time once reset is done, readable only here
        if (reg_write_in && s_ff.ready) begin
            if (reg_addr_in == fifo_flag_pkg::ADDR_EMPTY_OFS) begin
                nxt_s.empty_ofs = reg_wdata_in[OFS_W-1:0];
            end else if (reg_addr_in == fifo_flag_pkg::ADDR_FULL_OFS) begin
                nxt_s.full_ofs = reg_wdata_in[OFS_W-1:0];
            end
        end

        nxt_s.rdata = '0;
        if (reg_read_in) begin
            unique case (reg_addr_in)
                fifo_flag_pkg::ADDR_EMPTY_OFS: begin
                    nxt_s.rdata = fifo_flag_pkg::REG_W'(s_ff.empty_ofs);
                end
                fifo_flag_pkg::ADDR_FULL_OFS: begin
                    nxt_s.rdata = fifo_flag_pkg::REG_W'(s_ff.full_ofs);
                end
                fifo_flag_pkg::ADDR_STATUS: begin
                    nxt_s.rdata = status;
                end
                default: begin
                    nxt_s.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_ff <= '{
                init_cnt: 2'h0,
                ready: 1'b0,
                fall_through: 1'b0,
                serial: 1'b0,
                empty_ofs: '0,
                full_ofs: '0,
                wptr: '0,
                rptr: '0,
                held: '0,
                out_st: fifo_flag_pkg::OUT_EMPTY,
                fall_cnt: 2'h0,
                dout: '0,
                ef1: 1'b0,
                ef2: 1'b0,
                ff1: 1'b1,
                ff2: 1'b1,
                ir1: 1'b0,
                ir2: 1'b0,
                almost_empty_flag_n: 1'b0,
                almost_full_flag_n: 1'b1,
                hf: 1'b1,
                rdata: '0
            };
        end else begin
            s_ff <= nxt_s;
        end
    end

    // array has no reset: contents are undefined until written
    always_ff @(posedge mclk_in) begin
        if (wr_ok) begin
            mem[s_ff.wptr] <= din;
        end
    end

    assign reg_rdata_out = s_ff.rdata;
    assign data_out = s_ff.dout;
    assign empty_flag_n_out = s_ff.ef2;
    assign full_flag_n_out = s_ff.ff2;
    assign output_ready_n_out = (s_ff.out_st != fifo_flag_pkg::OUT_VALID);
    assign input_ready_n_out = s_ff.ir2;
    assign almost_empty_flag_n_out = s_ff.almost_empty_flag_n;
    assign almost_full_flag_n_out = s_ff.almost_full_flag_n;
    assign half_full_flag_n_out = s_ff.hf;
    assign fall_through_mode_out = s_ff.fall_through;
endmodule // dual_clock_fifo_flag_modes

// [rtl/fifo_flag_pkg.sv]
package fifo_flag_pkg;
    // word and offset geometry
    localparam int unsigned DEPTH_SMALL = 65536;
    localparam int unsigned DEPTH_LARGE = 131072;
    localparam int unsigned DATA_W = 9;
    localparam int unsigned OFS_W = 17;

    // offset presets chosen by the loading method at master reset
    localparam logic [16:0] OFS_SERIAL_PRESET = 17'h003FF;
    localparam logic [16:0] OFS_PARALLEL_PRESET = 17'h0007F;

    // register port map (word addresses)
    localparam logic [1:0] ADDR_EMPTY_OFS = 2'h0;
    localparam logic [1:0] ADDR_FULL_OFS = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;
    localparam int unsigned REG_W = 32;

    // status word field positions
    localparam int unsigned ST_FALL_THROUGH = 0;
    localparam int unsigned ST_SERIAL = 1;
    localparam int unsigned ST_EMPTY_N = 2;
    localparam int unsigned ST_FULL_N = 3;
    localparam int unsigned ST_OUT_READY_N = 4;
    localparam int unsigned ST_IN_READY_N = 5;
    localparam int unsigned ST_ALMOST_EMPTY_N = 6;
    localparam int unsigned ST_ALMOST_FULL_N = 7;
    localparam int unsigned ST_HALF_FULL_N = 8;
    localparam int unsigned ST_COUNT_LSB = 12;

    // sampled pin vector layout
    localparam int unsigned PIN_WCLK = 0;
    localparam int unsigned PIN_RCLK = 1;
    localparam int unsigned PIN_WEN = 2;
    localparam int unsigned PIN_REN = 3;
    localparam int unsigned PIN_MODE = 4;
    localparam int unsigned PIN_LOAD = 5;
    localparam int unsigned PIN_DATA = 6;
    localparam int unsigned PINS_W = PIN_DATA + DATA_W;

    // timing counts, in events of the respective clock
    localparam logic [1:0] INIT_WAIT = 2'h3;
    localparam logic [1:0] FALL_LOAD_AT = 2'h1;

    typedef enum logic [1:0] {
        OUT_EMPTY = 2'h0,
        OUT_FALLING = 2'h1,
        OUT_VALID = 2'h3
    } out_state_t;
endpackage

// [rtl/pin_sample_if.sv]
interface pin_sample_if #(parameter int unsigned W = 1);
    logic [W-1:0] pins;
    logic [W-1:0] level;
    logic [W-1:0] rise;
    modport sampler (input pins, output level, output rise);
    modport user (output pins, input level, input rise);
endinterface

// [rtl/pin_sampler.sv]
module pin_sampler #(
    parameter int unsigned W = 1
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    pin_sample_if.sampler smp
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
    } smp_state_t;

    smp_state_t s_ff;
    smp_state_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.meta = smp.pins;
        nxt_s.sync = s_ff.meta;
        nxt_s.prev = s_ff.sync;
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // edges are found between second and third stage only
    assign smp.level = s_ff.sync;
    assign smp.rise = s_ff.sync & ~s_ff.prev;
endmodule // pin_sampler

// [test/fifo_peer.sv]
module fifo_peer (
    output logic write_clock_out,
    output logic read_clock_out,
    output logic write_enable_n_out,
    output logic read_enable_n_out,
    output logic [fifo_flag_pkg::DATA_W-1:0] word_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        write_clock_out = 1'b0;
        read_clock_out = 1'b0;
        write_enable_n_out = 1'b1;
        read_enable_n_out = 1'b1;
        word_out = '0;
    end

    // both pin clocks run free at 320 ns; the read clock is offset so edges never line up
    always #160 write_clock_out = ~write_clock_out;
    initial begin
        #113;
        forever #160 read_clock_out = ~read_clock_out;
    end

    // controls move on the falling edge so each rising edge sees settled levels
    task automatic push(input logic [fifo_flag_pkg::DATA_W-1:0] w);
        @(negedge write_clock_out);
        write_enable_n_out <= 1'b0;
        word_out <= w;
        @(negedge write_clock_out);
        write_enable_n_out <= 1'b1;
        // released data shows the inverse so a late capture cannot pass by luck
        word_out <= ~w;
    endtask

    task automatic pop();
        @(negedge read_clock_out);
        read_enable_n_out <= 1'b0;
        @(negedge read_clock_out);
        read_enable_n_out <= 1'b1;
    endtask
endmodule // fifo_peer

// [test/fifo_flag_chk.sv]
module fifo_flag_chk #(
    parameter int unsigned DEPTH = 16
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic mode_select_serial_in,
    input wire logic [1:0] reg_addr_in,
    input wire logic reg_read_in,
    input wire logic [fifo_flag_pkg::REG_W-1:0] reg_rdata_out,
    input wire logic empty_flag_n_out,
    input wire logic full_flag_n_out,
    input wire logic output_ready_n_out,
    input wire logic input_ready_n_out,
    input wire logic almost_empty_flag_n_out,
    input wire logic half_full_flag_n_out,
    input wire logic fall_through_mode_out
);
    logic [3:0] run_cnt_ff;

    // saturating age since reset release; the strap is captured well before it tops out
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            run_cnt_ff <= 4'h0;
        end else if (run_cnt_ff != 4'hF) begin
            run_cnt_ff <= run_cnt_ff + 4'h1;
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_rd_ofs;
        reg_read_in && reg_addr_in != fifo_flag_pkg::ADDR_STATUS;
    endsequence
    sequence s_rd_status;
        reg_read_in && reg_addr_in == fifo_flag_pkg::ADDR_STATUS;
    endsequence

    a_mode_follows_strap: assert property (fall_through_mode_out |-> mode_select_serial_in)
        else $error("mode output high while strap low");
    a_mode_held: assert property (run_cnt_ff == 4'hF |-> $stable(fall_through_mode_out))
        else $error("latched mode changed after capture");
    a_std_no_ready: assert property ((run_cnt_ff == 4'hF && !fall_through_mode_out)
        |-> output_ready_n_out)
        else $error("output ready asserted in standard mode");
    a_full_not_empty: assert property (!full_flag_n_out |-> empty_flag_n_out)
        else $error("full and empty flags low together");
    a_full_half: assert property (!full_flag_n_out |-> !half_full_flag_n_out)
        else $error("full without half full");
    a_ir_half: assert property (input_ready_n_out |-> !half_full_flag_n_out)
        else $error("input blocked without half full");
    a_ae_needs_data: assert property (almost_empty_flag_n_out
        |-> (fall_through_mode_out ? !output_ready_n_out : empty_flag_n_out))
        else $error("almost empty released while fifo shows empty");
    a_rdata_quiet: assert property (!reg_read_in |=> reg_rdata_out == '0)
        else $error("read data without a read strobe");
    a_ofs_upper_zero: assert property (s_rd_ofs |=> reg_rdata_out[31:17] == '0)
        else $error("offset readback upper bits not zero");
    a_status_mode: assert property (s_rd_status
        |=> reg_rdata_out[fifo_flag_pkg::ST_FALL_THROUGH] == fall_through_mode_out)
        else $error("status mode bit differs from mode output");
endmodule // fifo_flag_chk

bind dual_clock_fifo_flag_modes fifo_flag_chk #(.DEPTH(DEPTH)) chk_u (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .mode_select_serial_in(mode_select_serial_in),
    .reg_addr_in(reg_addr_in),
    .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out),
    .empty_flag_n_out(empty_flag_n_out),
    .full_flag_n_out(full_flag_n_out),
    .output_ready_n_out(output_ready_n_out),
    .input_ready_n_out(input_ready_n_out),
    .almost_empty_flag_n_out(almost_empty_flag_n_out),
    .half_full_flag_n_out(half_full_flag_n_out),
    .fall_through_mode_out(fall_through_mode_out)
);

// [test/tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // small depth keeps every threshold reachable in a short run
    localparam int DEPTH = 16;
    localparam int N_OFS = 2;
    localparam int M_OFS = 2;
    localparam int LIMIT = 8000;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic mode_select_serial_in = 1'b0;
    logic load_n_in = 1'b0;
    logic [1:0] reg_addr_in = 2'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic write_clock_in, read_clock_in, write_enable_n_in, read_enable_n_in;
    logic [8:0] data_in;
    logic [8:0] data_out;
    logic [31:0] reg_rdata_out;
    logic empty_flag_n_out, full_flag_n_out, output_ready_n_out, input_ready_n_out;
    logic almost_empty_flag_n_out, almost_full_flag_n_out, half_full_flag_n_out;
    logic fall_through_mode_out;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    logic [8:0] q[$];

    always #20 mclk_in = ~mclk_in;

    dual_clock_fifo_flag_modes #(.DEPTH(DEPTH)) dut_u (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .write_clock_in(write_clock_in), .read_clock_in(read_clock_in),
        .write_enable_n_in(write_enable_n_in), .read_enable_n_in(read_enable_n_in),
        .data_in(data_in), .mode_select_serial_in(mode_select_serial_in),
        .load_n_in(load_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
        .reg_rdata_out(reg_rdata_out), .data_out(data_out),
        .empty_flag_n_out(empty_flag_n_out), .full_flag_n_out(full_flag_n_out),
        .output_ready_n_out(output_ready_n_out), .input_ready_n_out(input_ready_n_out),
        .almost_empty_flag_n_out(almost_empty_flag_n_out),
        .almost_full_flag_n_out(almost_full_flag_n_out),
        .half_full_flag_n_out(half_full_flag_n_out),
        .fall_through_mode_out(fall_through_mode_out)
    );

    fifo_peer peer_u (
        .write_clock_out(write_clock_in), .read_clock_out(read_clock_in),
        .write_enable_n_out(write_enable_n_in), .read_enable_n_out(read_enable_n_in),
        .word_out(data_in)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge mclk_in);
        reg_write_in <= 1'b0;
    endtask

    task automatic reg_rd(input logic [1:0] a, output logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge mclk_in);
        reg_read_in <= 1'b0;
        @(negedge mclk_in);
        d = reg_rdata_out;
    endtask

    // three pin-clock periods covers the longest flag pipeline
    task automatic settle();
        repeat (24) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask

    task automatic check_flags(input bit ft);
        int c;
        int e;
        logic [4:0] seen;
        logic [4:0] exp;
        c = q.size();
        e = int'(ft);
        seen = {ft ? output_ready_n_out : empty_flag_n_out,
                ft ? input_ready_n_out : full_flag_n_out,
                almost_empty_flag_n_out, almost_full_flag_n_out, half_full_flag_n_out};
        exp = {(c > 0) ^ ft, (c < DEPTH + e) ^ ft, c > N_OFS + e, c < DEPTH + e - M_OFS,
               c < DEPTH / 2 + 1 + e};
        check(32'(seen), 32'(exp));
        if (ft && c > 0) check(32'(data_out), 32'(q[0]));
    endtask

    task automatic run_mode(input bit ft, input bit ld);
        logic [31:0] r;
        logic [31:0] pre;
        logic [8:0] w;
        bit mixed_done = 1'b0;
        pre = ld ? 32'(fifo_flag_pkg::OFS_SERIAL_PRESET) : 32'(fifo_flag_pkg::OFS_PARALLEL_PRESET);
        @(posedge mclk_in);
        reset_n_in <= 1'b0;
        mode_select_serial_in <= ft;
        load_n_in <= ld;
        repeat (5) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        repeat (8) @(posedge mclk_in);
        q.delete();
        reg_rd(fifo_flag_pkg::ADDR_EMPTY_OFS, r);
        check(r, pre);
        reg_rd(fifo_flag_pkg::ADDR_FULL_OFS, r);
        check(r, pre);
        reg_rd(fifo_flag_pkg::ADDR_STATUS, r);
        check(32'(r[1:0]), 32'({ld, ft}));
        check(32'(fall_through_mode_out), 32'(ft));
        reg_rd(2'h3, r);
        check(r, 32'h0);
        reg_wr(fifo_flag_pkg::ADDR_EMPTY_OFS, 32'hFFFE_0000 | 32'(N_OFS));
        reg_wr(fifo_flag_pkg::ADDR_FULL_OFS, 32'(M_OFS));
        reg_rd(fifo_flag_pkg::ADDR_EMPTY_OFS, r);
        check(r, 32'(N_OFS));
        settle();
        check_flags(ft);
        // writes to depth plus two: two past capacity in standard, one in fall-through; the surplus must be dropped
        for (int i = 1; i <= DEPTH + 2; i++) begin
            w = 9'(i * 23 + 5);
            peer_u.push(w);
            if (q.size() < DEPTH + int'(ft)) q.push_back(w);
            settle();
            check_flags(ft);
        end
        while (q.size() > 0) begin
            // the mixed step runs once: the level stays at six, so repeating it never drains
            if (q.size() == 6 && !mixed_done) begin
                fork
                    peer_u.push(9'h1C3);
                    peer_u.pop();
                join
                q.push_back(9'h1C3);
                mixed_done = 1'b1;
            end else begin
                peer_u.pop();
            end
            w = q.pop_front();
            settle();
            if (!ft) check(32'(data_out), 32'(w));
            check_flags(ft);
        end
        // a read on an empty fifo changes nothing
        peer_u.pop();
        settle();
        check_flags(ft);
        if (!ft) check(32'(data_out), 32'(w));
    endtask

    task automatic wrap_up();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            wrap_up();
        end
    end

    initial begin
        run_mode(1'b0, 1'b0);
        run_mode(1'b1, 1'b1);
        wrap_up();
    end
endmodule // tb_top
